// ==== src/iexu_params.svh ====
// Constants for the instruction exception unit
`ifndef IEXU_PARAMS_SVH
`define IEXU_PARAMS_SVH
`define IEXU_VEC_SCALE      32'h0000_0004
`define IEXU_SLOT_DEC       32'h0000_0004
`define IEXU_VEC_ILL_GEN    8'h04
`define IEXU_VEC_ILL_SLOT   8'h06
`define IEXU_VEC_ADDR_ERR   8'h09
`define IEXU_ALIGN_MASK     32'h0000_0003
`define IEXU_ZERO_WORD      32'h0000_0000
`endif

// ==== src/iexu_pkg.sv ====
// Types shared by the instruction exception unit
package iexu_pkg;
  typedef enum logic [2:0] {
    IEXU_IDLE   = 3'b000,
    IEXU_PUSH_S = 3'b001,
    IEXU_PUSH_P = 3'b010,
    IEXU_VFETCH = 3'b011,
    IEXU_DONE   = 3'b100
  } iexu_state_t;

  typedef enum logic [2:0] {
    IEXU_EX_NONE = 3'b000,
    IEXU_EX_TRAP = 3'b001,
    IEXU_EX_SLOT = 3'b010,
    IEXU_EX_ILL  = 3'b011,
    IEXU_EX_AERR = 3'b100,
    IEXU_EX_INT  = 3'b101
  } iexu_cause_t;
endpackage

// ==== src/iexu_classify.sv ====
// Instruction class decoder for the instruction exception unit
`timescale 1ns/1ps
module iexu_classify
(
  // Decoded instruction class flags
  input  wire logic is_jump,
  input  wire logic is_jsub,
  input  wire logic is_bra,
  input  wire logic is_bsub,
  input  wire logic is_rts,
  input  wire logic is_rte,
  input  wire logic is_bt,
  input  wire logic is_bf,
  input  wire logic is_trap,
  input  wire logic is_ldc,
  input  wire logic is_stc,
  input  wire logic is_lds,
  input  wire logic is_sts,
  // Class results
  output logic      delayed_branch,
  output logic      pc_rewrite,
  output logic      irq_disable
);
  // Delayed branches and every PC-writing instruction
  assign delayed_branch = is_jump | is_jsub | is_bra | is_bsub | is_rts | is_rte;
  assign pc_rewrite     = delayed_branch | is_bt | is_bf | is_trap;
  // Control and system register moves, memory forms included by the decoder
  assign irq_disable    = is_ldc | is_stc | is_lds | is_sts;
endmodule

// ==== src/iexu_top.sv ====
// Instruction exception unit: detection, deferral, stacking and vector fetch
// Contract
// - A trap pushes the status word first, then the address after the trap.
// - A trap reads its handler from the vector its instruction encodes, undelayed.
// - An undefined code in a delay slot starts illegal-slot handling at its decode.
// - A PC-writing instruction in a delay slot also starts illegal-slot handling.
// - Illegal-slot pushes status, then the prior branch target, then vectors undelayed.
// - An undefined code outside a slot does the same but saves its own address.
// - Interrupts and address errors are not taken at decode of a slot instruction.
// - After an interrupt-disabling instruction interrupts wait, address errors do not.
// - A held-off exception is taken at the next decode allowed to take it.
// - Control and system register loads and stores form the interrupt-disabling class.
// - Jumps, relative branches, subroutine calls and both returns are delayed branches.
// - Stacking with a stack pointer not a multiple of four raises an address error.
// - A vector fetch with a misaligned vector base raises an address error.
// - A stacking address error is taken after the current sequence finishes.
// - Stacking errors during address error handling itself are ignored.
// - A misaligned stack write is still issued at the plain pointer, minus four each.
// - The vector address is the vector base plus four times the vector number.
`timescale 1ns/1ps
`include "iexu_params.svh"
module iexu_top
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Decode stage
  input  wire logic        dec_valid,
  input  wire logic        dec_undef,
  input  wire logic        dec_jump,
  input  wire logic        dec_jsub,
  input  wire logic        dec_bra,
  input  wire logic        dec_bsub,
  input  wire logic        dec_rts,
  input  wire logic        dec_rte,
  input  wire logic        dec_bt,
  input  wire logic        dec_bf,
  input  wire logic        dec_trap,
  input  wire logic        dec_ldc,
  input  wire logic        dec_stc,
  input  wire logic        dec_lds,
  input  wire logic        dec_sts,
  input  wire logic [7:0]  dec_trap_vec,
  input  wire logic [31:0] dec_pc,
  input  wire logic [31:0] dec_next_pc,
  input  wire logic [31:0] dec_branch_target,
  // Pending external events
  input  wire logic        int_req,
  input  wire logic [7:0]  int_vec,
  input  wire logic        addr_err_req,
  // Core state
  input  wire logic [31:0] status_word,
  input  wire logic [31:0] stack_ptr,
  input  wire logic [31:0] vector_base_pointer,
  // Bus interface
  input  wire logic        bus_done,
  input  wire logic [31:0] bus_rdata,
  output logic             bus_req,
  output logic             bus_write,
  output logic [31:0]      bus_addr,
  output logic [31:0]      bus_wdata,
  // Pipeline control
  output logic             exc_busy,
  output logic             int_ack,
  output logic             addr_err_ack,
  output logic             pc_load,
  output logic [31:0]      pc_value,
  output logic             sp_load,
  output logic [31:0]      sp_value
);
  // ----------------------------------------------------------------
  // Instruction classes
  // ----------------------------------------------------------------
  logic delayed_branch;
  logic pc_rewrite;
  logic irq_disable;

  iexu_classify u_class
  (
    .is_jump        (dec_jump),
    .is_jsub        (dec_jsub),
    .is_bra         (dec_bra),
    .is_bsub        (dec_bsub),
    .is_rts         (dec_rts),
    .is_rte         (dec_rte),
    .is_bt          (dec_bt),
    .is_bf          (dec_bf),
    .is_trap        (dec_trap),
    .is_ldc         (dec_ldc),
    .is_stc         (dec_stc),
    .is_lds         (dec_lds),
    .is_sts         (dec_sts),
    .delayed_branch (delayed_branch),
    .pc_rewrite     (pc_rewrite),
    .irq_disable    (irq_disable)
  );

  // ----------------------------------------------------------------
  // Decode history and acceptance
  // ----------------------------------------------------------------
  iexu_pkg::iexu_state_t state_reg;
  iexu_pkg::iexu_cause_t cause_reg;
  logic        in_slot_reg;
  logic        after_irqdis_reg;
  logic [31:0] slot_target_reg;
  logic        pend_aerr_reg;
  logic        aerr_mode_reg;
  logic [31:0] save_pc_reg;
  logic [31:0] save_sr_reg;
  logic [7:0]  vec_reg;
  logic [31:0] sp_reg;

  logic        idle;
  logic        take_slot;
  logic        take_ill;
  logic        take_trap;
  logic        aerr_ok;
  logic        int_ok;
  logic        take_aerr;
  logic        take_int;
  logic        start;
  logic        stack_misalign;

  assign idle = (state_reg == iexu_pkg::IEXU_IDLE);
  // A slot instruction never lets anything in between it and its branch
  assign take_slot = idle && dec_valid && in_slot_reg && (dec_undef || pc_rewrite);
  assign take_ill  = idle && dec_valid && !in_slot_reg && dec_undef;
  assign take_trap = idle && dec_valid && !in_slot_reg && dec_trap && !dec_undef;
  assign aerr_ok   = !in_slot_reg;
  assign int_ok    = !in_slot_reg && !after_irqdis_reg;
  // Deferred requests stay at the input, stacking errors in pend_aerr_reg; all are taken at the next permitted decode
  assign take_aerr = idle && dec_valid && aerr_ok && (addr_err_req || pend_aerr_reg)
                     && !take_slot;
  assign take_int  = idle && dec_valid && int_ok && int_req && !take_aerr && !take_slot
                     && !take_ill && !take_trap;
  assign start     = take_slot || take_ill || take_trap || take_aerr || take_int;
  assign stack_misalign = |(sp_reg & `IEXU_ALIGN_MASK);

  // Track whether the decoding instruction sits in a delay slot
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      in_slot_reg      <= 1'b0;
      after_irqdis_reg <= 1'b0;
      slot_target_reg  <= `IEXU_ZERO_WORD;
    end
    else if (start)
    begin
      in_slot_reg      <= 1'b0;
      after_irqdis_reg <= 1'b0;
    end
    else if (idle && dec_valid)
    begin
      in_slot_reg      <= delayed_branch && !in_slot_reg;
      after_irqdis_reg <= irq_disable;
      if (delayed_branch)
      begin
        slot_target_reg <= dec_branch_target;  // Saved PC for illegal-slot
      end
    end
  end

  // ----------------------------------------------------------------
  // Exception sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg   <= iexu_pkg::IEXU_IDLE;
      cause_reg   <= iexu_pkg::IEXU_EX_NONE;
      save_pc_reg <= `IEXU_ZERO_WORD;
      save_sr_reg <= `IEXU_ZERO_WORD;
      vec_reg     <= 8'h00;
      sp_reg      <= `IEXU_ZERO_WORD;
    end
    else
    begin
      case (state_reg)
        iexu_pkg::IEXU_IDLE:
        begin
          if (start)
          begin
            state_reg   <= iexu_pkg::IEXU_PUSH_S;
            save_sr_reg <= status_word;
            sp_reg      <= stack_ptr;
            if (take_slot)
            begin
              cause_reg   <= iexu_pkg::IEXU_EX_SLOT;
              save_pc_reg <= slot_target_reg;
              vec_reg     <= `IEXU_VEC_ILL_SLOT;
            end
            else if (take_aerr)
            begin
              cause_reg   <= iexu_pkg::IEXU_EX_AERR;
              save_pc_reg <= dec_pc;
              vec_reg     <= `IEXU_VEC_ADDR_ERR;
            end
            else if (take_ill)
            begin
              cause_reg   <= iexu_pkg::IEXU_EX_ILL;
              save_pc_reg <= dec_pc;
              vec_reg     <= `IEXU_VEC_ILL_GEN;
            end
            else if (take_trap)
            begin
              cause_reg   <= iexu_pkg::IEXU_EX_TRAP;
              save_pc_reg <= dec_next_pc;
              vec_reg     <= dec_trap_vec;
            end
            else
            begin
              cause_reg   <= iexu_pkg::IEXU_EX_INT;
              save_pc_reg <= dec_pc;
              vec_reg     <= int_vec;
            end
          end
        end
        iexu_pkg::IEXU_PUSH_S:
        begin
          if (bus_done)
          begin
            state_reg <= iexu_pkg::IEXU_PUSH_P;        // Status word first
            sp_reg    <= sp_reg - `IEXU_SLOT_DEC;
          end
        end
        iexu_pkg::IEXU_PUSH_P:
        begin
          if (bus_done)
          begin
            state_reg <= iexu_pkg::IEXU_VFETCH;
            sp_reg    <= sp_reg - `IEXU_SLOT_DEC;
          end
        end
        iexu_pkg::IEXU_VFETCH:
        begin
          if (bus_done)
          begin
            state_reg <= iexu_pkg::IEXU_DONE;
          end
        end
        iexu_pkg::IEXU_DONE:
        begin
          state_reg <= iexu_pkg::IEXU_IDLE;
        end
        default:
        begin
          state_reg <= iexu_pkg::IEXU_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Internal address errors from stacking and vector fetch
  // ----------------------------------------------------------------
  // Held until the current sequence completes; the address error sequence
  // itself never raises one, which stops an endless chain of faults.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pend_aerr_reg <= 1'b0;
      aerr_mode_reg <= 1'b0;
    end
    else
    begin
      if (idle && start)
      begin
        aerr_mode_reg <= take_aerr;
      end
      if ((state_reg == iexu_pkg::IEXU_PUSH_S || state_reg == iexu_pkg::IEXU_PUSH_P)
          && bus_done && stack_misalign && !aerr_mode_reg)
      begin
        pend_aerr_reg <= 1'b1;
      end
      else if (state_reg == iexu_pkg::IEXU_VFETCH && bus_done && !aerr_mode_reg
               && |(vector_base_pointer & `IEXU_ALIGN_MASK))
      begin
        pend_aerr_reg <= 1'b1;
      end
      else if (take_aerr)
      begin
        pend_aerr_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus requests and pipeline outputs, all registered
  // ----------------------------------------------------------------
  logic [31:0] vec_addr;
  assign vec_addr = vector_base_pointer + {22'h00_0000, vec_reg, 2'b00};

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bus_req   <= 1'b0;
      bus_write <= 1'b0;
      bus_addr  <= `IEXU_ZERO_WORD;
      bus_wdata <= `IEXU_ZERO_WORD;
    end
    else
    begin
      bus_req <= 1'b0;
      if (state_reg == iexu_pkg::IEXU_PUSH_S && !bus_done)
      begin
        bus_req   <= 1'b1;
        bus_write <= 1'b1;
        bus_addr  <= sp_reg - `IEXU_SLOT_DEC;  // Written even when misaligned
        bus_wdata <= save_sr_reg;
      end
      else if (state_reg == iexu_pkg::IEXU_PUSH_P && !bus_done)
      begin
        bus_req   <= 1'b1;
        bus_write <= 1'b1;
        bus_addr  <= sp_reg - `IEXU_SLOT_DEC;
        bus_wdata <= save_pc_reg;
      end
      else if (state_reg == iexu_pkg::IEXU_VFETCH && !bus_done)
      begin
        bus_req   <= 1'b1;
        bus_write <= 1'b0;
        bus_addr  <= vec_addr;
      end
    end
  end

  // Handshake and jump outputs; the jump is taken directly, no slot
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      exc_busy     <= 1'b0;
      int_ack      <= 1'b0;
      addr_err_ack <= 1'b0;
      pc_load      <= 1'b0;
      pc_value     <= `IEXU_ZERO_WORD;
      sp_load      <= 1'b0;
      sp_value     <= `IEXU_ZERO_WORD;
    end
    else
    begin
      exc_busy     <= !idle || start;
      int_ack      <= take_int;
      addr_err_ack <= take_aerr && addr_err_req;
      pc_load      <= state_reg == iexu_pkg::IEXU_VFETCH && bus_done;
      sp_load      <= state_reg == iexu_pkg::IEXU_VFETCH && bus_done;
      if (state_reg == iexu_pkg::IEXU_VFETCH && bus_done)
      begin
        pc_value <= bus_rdata;
        sp_value <= sp_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_slot_start;
    @(posedge clk) disable iff (rst)
    take_slot |=> state_reg == iexu_pkg::IEXU_PUSH_S && save_pc_reg == $past(slot_target_reg);
  endproperty
  a_slot_start: assert property (p_slot_start) else $error("slot exception not started");

  // Judged on what follows the decode, not on the take terms themselves
  property p_no_int_in_slot;
    @(posedge clk) disable iff (rst)
    idle && dec_valid && in_slot_reg && !dec_undef && !pc_rewrite
      |=> state_reg == iexu_pkg::IEXU_IDLE && !int_ack && !addr_err_ack;
  endproperty
  a_no_int_in_slot: assert property (p_no_int_in_slot) else $error("event taken in slot");

  property p_irqdis;
    @(posedge clk) disable iff (rst)
    idle && dec_valid && after_irqdis_reg && !in_slot_reg && !dec_undef && !dec_trap
      && !addr_err_req && !pend_aerr_reg |=> state_reg == iexu_pkg::IEXU_IDLE && !int_ack;
  endproperty
  a_irqdis: assert property (p_irqdis) else $error("interrupt after disabling instr");

  property p_trap_pc;
    @(posedge clk) disable iff (rst)
    take_trap && !take_aerr
      |=> save_pc_reg == $past(dec_next_pc) && vec_reg == $past(dec_trap_vec);
  endproperty
  a_trap_pc: assert property (p_trap_pc) else $error("trap saved pc wrong");

  property p_ill_pc;
    @(posedge clk) disable iff (rst)
    take_ill && !take_aerr |=> save_pc_reg == $past(dec_pc) && vec_reg == `IEXU_VEC_ILL_GEN;
  endproperty
  a_ill_pc: assert property (p_ill_pc) else $error("illegal saved pc wrong");

  property p_order;
    @(posedge clk) disable iff (rst)
    state_reg == iexu_pkg::IEXU_PUSH_S && bus_done |=> state_reg == iexu_pkg::IEXU_PUSH_P;
  endproperty
  a_order: assert property (p_order) else $error("status not pushed first");

  property p_vaddr;
    @(posedge clk) disable iff (rst)
    bus_req && !bus_write |-> bus_addr == vector_base_pointer + {22'h00_0000, vec_reg, 2'b00};
  endproperty
  a_vaddr: assert property (p_vaddr) else $error("vector address wrong");

  property p_sp_dec;
    @(posedge clk) disable iff (rst)
    state_reg == iexu_pkg::IEXU_PUSH_P && bus_done |=> sp_reg == $past(sp_reg) - 32'h0000_0004;
  endproperty
  a_sp_dec: assert property (p_sp_dec) else $error("stack pointer not stepped");

  property p_aerr_ignored;
    @(posedge clk) disable iff (rst)
    aerr_mode_reg && !pend_aerr_reg && !idle |=> !pend_aerr_reg;
  endproperty
  a_aerr_ignored: assert property (p_aerr_ignored) else $error("recursive addr error");

  property p_stack_err;
    @(posedge clk) disable iff (rst)
    state_reg == iexu_pkg::IEXU_PUSH_S && bus_done && stack_misalign && !aerr_mode_reg
      |=> pend_aerr_reg;
  endproperty
  a_stack_err: assert property (p_stack_err) else $error("stack error missed");
endmodule

// ==== bench/iexu_bus_model.sv ====
// Bus responder that completes the unit's stack writes and vector reads
`timescale 1ns/1ps
module iexu_bus_model
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Requests from the unit
  input  wire logic        bus_req,
  input  wire logic        bus_write,
  input  wire logic [31:0] bus_addr,
  // Wait states chosen by the bench
  input  wire logic [3:0]  lat,
  // Answers to the unit
  output logic             bus_done,
  output logic [31:0]      bus_rdata
);
  logic [3:0] cnt_reg;
  logic       wait_low_reg;

  // ----------------------------------------
  // Response timing
  // ----------------------------------------
  // Wait for the request to drop after each answer, so a long request is never completed twice
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_reg      <= 4'h0;
      wait_low_reg <= 1'b0;
      bus_done     <= 1'b0;
    end
    else
    begin
      bus_done <= 1'b0;
      if (wait_low_reg)
      begin
        if (!bus_req)
          wait_low_reg <= 1'b0;
      end
      else if (bus_req && !bus_done)
      begin
        if (cnt_reg >= lat)
        begin
          bus_done     <= 1'b1;
          cnt_reg      <= 4'h0;
          wait_low_reg <= 1'b1;
        end
        else
          cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Data flips every cycle outside the answer, so a stale sample never looks right
  always_ff @(posedge clk)
  begin
    if (rst)
      bus_rdata <= 32'h0000_0000;
    else if (!wait_low_reg && bus_req && !bus_done && cnt_reg >= lat && !bus_write)
      bus_rdata <= ~bus_addr ^ 32'h1234_5678 & 32'hFFFF_FFFE;
    else
      bus_rdata <= ~bus_rdata;
  end
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the instruction exception unit
`timescale 1ns/1ps
`include "iexu_params.svh"
module testbench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk = 1'b0;
  logic        rst, dec_valid, int_req, addr_err_req, bus_done, bus_req, bus_write;
  logic        exc_busy, int_ack, addr_err_ack, pc_load, sp_load, seen_spl;
  logic [13:0] fl;
  logic [7:0]  dec_trap_vec, int_vec;
  logic [31:0] dec_pc, dec_branch_target, status_word, stack_ptr, vector_base_pointer;
  logic [31:0] bus_rdata, bus_addr, bus_wdata, pc_value, sp_value, tgt, seen_pc, seen_sp;
  logic [3:0]  lat;
  logic [64:0] acc_q[$];
  int          err_total = 0;
  int          compares = 0;
  int          cyc = 0;
  int          n_load = 0;
  int          n_int = 0;
  int          n_aerr = 0;

  iexu_top u_iexu_top (
    .clk(clk), .rst(rst), .dec_valid(dec_valid), .dec_undef(fl[13]), .dec_jump(fl[12]),
    .dec_jsub(fl[11]), .dec_bra(fl[10]), .dec_bsub(fl[9]), .dec_rts(fl[8]), .dec_rte(fl[7]),
    .dec_bt(fl[6]), .dec_bf(fl[5]), .dec_trap(fl[4]), .dec_ldc(fl[3]), .dec_stc(fl[2]),
    .dec_lds(fl[1]), .dec_sts(fl[0]), .dec_trap_vec(dec_trap_vec), .dec_pc(dec_pc),
    .dec_next_pc(dec_pc + 32'h0000_0002), .dec_branch_target(dec_branch_target),
    .int_req(int_req), .int_vec(int_vec), .addr_err_req(addr_err_req),
    .status_word(status_word), .stack_ptr(stack_ptr),
    .vector_base_pointer(vector_base_pointer), .bus_done(bus_done), .bus_rdata(bus_rdata),
    .bus_req(bus_req), .bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .exc_busy(exc_busy), .int_ack(int_ack), .addr_err_ack(addr_err_ack), .pc_load(pc_load),
    .pc_value(pc_value), .sp_load(sp_load), .sp_value(sp_value));

  iexu_bus_model u_iexu_bus_model (
    .clk(clk), .rst(rst), .bus_req(bus_req), .bus_write(bus_write), .bus_addr(bus_addr),
    .lat(lat), .bus_done(bus_done), .bus_rdata(bus_rdata));

  // Free-running core clock, 8 ns period
  always #4 clk = ~clk;

  // ----------------------------------------
  // Monitor and timeout
  // ----------------------------------------
  // Request sources drop their level once the unit acknowledges it
  always @(posedge clk)
  begin
    cyc++;
    if (bus_req === 1'b1 && bus_done === 1'b1)
      acc_q.push_back({bus_write, bus_addr, bus_wdata});
    if (pc_load === 1'b1)
    begin
      n_load++;
      seen_pc = pc_value;
      seen_sp = sp_value;
      seen_spl = sp_load;
    end
    if (int_ack === 1'b1)
    begin
      n_int++;
      int_req <= 1'b0;
    end
    if (addr_err_ack === 1'b1)
    begin
      n_aerr++;
      addr_err_req <= 1'b0;
    end
    if (cyc == 20000)
    begin
      err_total++;
      summarize();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("Checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One decode cycle with fresh addresses; the old branch target is lost on purpose
  task automatic dec(input logic [13:0] f);
    @(negedge clk);
    fl = f;
    dec_valid = 1'b1;
    dec_pc = $urandom() & 32'hFFFF_FFFE;
    dec_branch_target = $urandom() & 32'hFFFF_FFFE;
    @(negedge clk);
    dec_valid = 1'b0;
    fl = 14'h0000;
  endtask

  // Whole sequence: two pushes, vector read, undelayed handler load
  task automatic expect_exc(input logic [7:0] vec, input logic [31:0] sv_pc, input bit chk_pc,
                            input bit chk_dat);
    logic [31:0] sp;
    logic [31:0] sw;
    logic [31:0] va;
    logic [64:0] a;
    int          n;
    int          t;
    sp = stack_ptr;
    sw = status_word;
    va = vector_base_pointer + (32'(vec) << 2);
    n = n_load;
    t = 0;
    seen_spl = 1'b0;
    while (n_load == n && t < 300)
    begin
      @(posedge clk);
      t++;
    end
    check("handler_loads", n_load - n, 1);
    check("access_count", acc_q.size(), 3);
    while (acc_q.size() < 3)
      acc_q.push_back('1);
    a = acc_q.pop_front();
    check("push1_write", a[64], 1'b1);
    check("push1_addr", a[63:32], sp - 32'h0000_0004);
    if (chk_dat)
      check("push1_data", a[31:0], sw);
    a = acc_q.pop_front();
    check("push2_write", a[64], 1'b1);
    check("push2_addr", a[63:32], sp - 32'h0000_0008);
    if (chk_dat && chk_pc)
      check("push2_data", a[31:0], sv_pc);
    a = acc_q.pop_front();
    check("vec_read", a[64], 1'b0);
    check("vec_addr", a[63:32], va);
    check("handler", seen_pc, ~va ^ 32'h1234_5678 & 32'hFFFF_FFFE);
    check("new_sp", seen_sp, sp - 32'h0000_0008);
    check("sp_load", seen_spl, 1'b1);
    t = 0;
    while (exc_busy !== 1'b0 && t < 50)
    begin
      @(posedge clk);
      t++;
    end
    @(negedge clk);
    stack_ptr = seen_sp;
    acc_q.delete();
  endtask

  // Nothing was taken: unit idle and acknowledge counts as expected
  task automatic no_exc(input int ni, input int na);
    repeat (3) @(posedge clk);
    #1;
    check("idle_busy", exc_busy, 1'b0);
    check("int_taken", n_int, ni);
    check("aerr_taken", n_aerr, na);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rst = 1'b1;
    dec_valid = 1'b0;
    fl = 14'h0000;
    int_req = 1'b0;
    addr_err_req = 1'b0;
    lat = 4'h0;
    void'($urandom(51570));
    int_vec = 8'h40;
    dec_trap_vec = 8'h00;
    dec_pc = 32'h0000_0000;
    dec_branch_target = 32'h0000_0000;
    status_word = $urandom();
    stack_ptr = ($urandom() & 32'h0FFF_FFF0) | 32'h0010_0000;
    vector_base_pointer = $urandom() & 32'h0FFF_FFFC;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    // Traps, extreme vectors first, random wait states
    for (int i = 0; i < 6; i++)
    begin
      lat = 4'($urandom_range(0, 6));
      status_word = $urandom();
      dec_trap_vec = (i == 0) ? 8'hFF : ((i == 1) ? 8'h00 : 8'($urandom()));
      dec(14'h0010);
      expect_exc(dec_trap_vec, dec_pc + 32'h0000_0002, 1, 1);
    end
    // Every delayed branch, then every PC writer and an undefined code in its slot
    for (int i = 0; i < 10; i++)
    begin
      dec(14'h1000 >> (i % 6));
      tgt = dec_branch_target;
      dec((i == 9) ? 14'h2000 : (14'h1000 >> i));
      expect_exc(`IEXU_VEC_ILL_SLOT, tgt, 1, 1);
    end
    // Undefined code outside a slot saves its own address
    dec(14'h0000);
    dec(14'h2000);
    expect_exc(`IEXU_VEC_ILL_GEN, dec_pc, 1, 1);
    // Interrupt, then address error, raised for a slot instruction
    for (int k = 0; k < 2; k++)
    begin
      dec(14'h1000 >> (k * 3));
      int_vec = $urandom();
      int_req = (k == 0);
      addr_err_req = (k == 1);
      dec(14'h0000);
      no_exc(n_int, n_aerr);
      dec(14'h0000);
      expect_exc((k == 0) ? int_vec : `IEXU_VEC_ADDR_ERR, 32'h0, 0, 1);
      no_exc(1, k);
    end
    // Each interrupt-disabling move holds off interrupts but not address errors
    for (int k = 0; k < 4; k++)
    begin
      dec(14'h0008 >> k);
      int_vec = $urandom();
      int_req = 1'b1;
      dec(14'h0000);
      no_exc(n_int, n_aerr);
      dec(14'h0000);
      expect_exc(int_vec, 32'h0, 0, 1);
      dec(14'h0008 >> k);
      addr_err_req = 1'b1;
      dec(14'h0000);
      expect_exc(`IEXU_VEC_ADDR_ERR, 32'h0, 0, 1);
      no_exc(k + 2, k + 2);
    end
    // Misaligned stack: writes still issued, error taken later, not repeated
    stack_ptr = stack_ptr | 32'h0000_0002;
    dec_trap_vec = 8'($urandom());
    dec(14'h0010);
    expect_exc(dec_trap_vec, 32'h0, 0, 0);
    dec(14'h0000);
    expect_exc(`IEXU_VEC_ADDR_ERR, 32'h0, 0, 0);
    dec(14'h0000);
    no_exc(n_int, n_aerr);
    stack_ptr = stack_ptr & 32'hFFFF_FFFC;
    // Misaligned vector base raises an address error after the trap
    vector_base_pointer = vector_base_pointer | 32'h0000_0001;
    dec(14'h0010);
    expect_exc(dec_trap_vec, dec_pc + 32'h0000_0002, 1, 1);
    dec(14'h0000);
    expect_exc(`IEXU_VEC_ADDR_ERR, 32'h0, 0, 1);
    dec(14'h0000);
    no_exc(n_int, n_aerr);
    summarize();
  end
endmodule
